// File: hdl/acc_mem_const_alu_ops.sv
// accumulator/memory and accumulator/constant execution datapath with apb access
// What this block does
// - memory logic ops OR, AND, XOR into accumulator, update ALU status.
// - byte load puts memory byte in accumulator low byte, zeroes upper byte.
// - byte store writes accumulator low byte to word lane chosen by address LSB.
// - memory compare sets ALU flags from accumulator minus memory, accumulator kept.
// - lookup reads program memory at accumulator address, writes data memory.
// - multiply-transfer loads product low to accumulator, high to product-high.
// - multiply add/subtract low product to accumulator, latch high product half.
// - parallel load fills multiplier signed, adds or subtracts product-high.
// - string bit on parallel loads chains carry and zero, runs once.
// - shift memory word left by shift value into 32 bits, sign or zero fill.
// - shift low half transfers, subtracts or adds to accumulator; high half latched.
// - short constant ops take one word and one execution cycle.
// - short constant add, load, subtract, OR, AND, XOR into accumulator.
// - short constant compare sets flags only, accumulator unchanged.
// - short constant into multiplier zeroes top byte, keeps mode, keeps status.
// - long constants take two words; two cycles, or string count plus two.
// - long constant is second word, or for strings the address of its LSW.
// - long constant ops pick source and destination accumulator by select bits.
// - long constant compare sets flags only, no register changed.
// - long constant into multiplier sets signed mode, flags unchanged.
// - string bit makes a memory-group instruction work on a multiword string.
`timescale 1ns/100ps
module acc_mem_const_alu_ops
  import acc_const_alu_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             busy
);

  logic                 rst_sync1_r;
  logic                 rst_n_r;
  logic [15:0]          acc_r [ACC_COUNT];
  logic [15:0]          dmem  [MEM_WORDS];
  logic [INSTR_W-1:0]   pmem  [MEM_WORDS];
  logic [15:0]          mr_r;
  logic [15:0]          ph_r;
  logic [15:0]          sv_r;
  logic [3:0]           str_len_r;
  logic                 um_r;
  logic                 sign_extension_mode_r;
  alu_status_t          st_r;
  exec_state_t          state_r;
  logic [MEM_AW-1:0]    pc_r;
  logic [INSTR_W-1:0]   instr_r;
  logic [INSTR_W-1:0]   second_r;
  logic [3:0]           cnt_r;
  logic                 pready_r;
  logic [31:0]          prdata_r;
  logic                 pslverr_r;
  logic                 busy_r;

  // reset release through two flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync1_r <= 1'b0;
      rst_n_r     <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_n_r     <= rst_sync1_r;
    end
  end

  // apb slave
  logic        apb_done;
  logic        apb_wr;
  logic        addr_hit;
  logic [31:0] rdata_nxt;
  logic        is_acc_a;
  logic        is_dmem_a;
  logic        is_pmem_a;

  assign apb_done  = psel & penable & pready_r;
  assign apb_wr    = apb_done & pwrite & addr_hit;
  assign is_acc_a  = (paddr[11:5] == ACC_PAGE);
  assign is_dmem_a = (paddr[11:8] == DMEM_PAGE);
  assign is_pmem_a = (paddr[11:8] == PMEM_PAGE);

  always_comb begin
    addr_hit  = 1'b1;
    rdata_nxt = 32'h0000_0000;
    if (is_acc_a) begin
      rdata_nxt[15:0] = acc_r[paddr[4:2]];
    end else if (is_dmem_a) begin
      rdata_nxt[15:0] = dmem[paddr[7:2]];
    end else if (is_pmem_a) begin
      rdata_nxt[INSTR_W-1:0] = pmem[paddr[7:2]];
    end else begin
      unique case (paddr)
        ADDR_CTRL: begin
          rdata_nxt[CTRL_BUSY] = busy_r;
          rdata_nxt[CTRL_PC_LO +: MEM_AW] = pc_r;
        end
        ADDR_STATUS: begin
          rdata_nxt[ST_CARRY] = st_r.carry;
          rdata_nxt[ST_ZERO]  = st_r.zero;
          rdata_nxt[ST_SIGN]  = st_r.sign;
          rdata_nxt[ST_UM]    = um_r;
          rdata_nxt[ST_SIGN_EXTENSION_MODE]  = sign_extension_mode_r;
        end
        ADDR_STRLEN: rdata_nxt[3:0]  = str_len_r;
        ADDR_MR:     rdata_nxt[15:0] = mr_r;
        ADDR_PH:     rdata_nxt[15:0] = ph_r;
        ADDR_SV:     rdata_nxt[15:0] = sv_r;
        default:     addr_hit = 1'b0;
      endcase
    end
  end

  // one wait state so answer comes from flops
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~addr_hit;
      if (psel & penable & ~pready_r & ~pwrite) begin
        prdata_r <= rdata_nxt;
      end
    end
  end

  // software writes to working state only while idle
  logic sw_wr;
  assign sw_wr = apb_wr & ~busy_r;

  // decode
  logic [3:0]  c1b;
  logic [2:0]  c2a;
  logic [2:0]  c2b;
  logic [1:0]  an;
  logic [7:0]  adrs;
  logic        is_c1b;
  logic        is_c2a;
  logic        is_c2b;
  logic        par_load;
  logic        is_string;
  logic [3:0]  last_cnt;
  logic        fetch_c2b;

  assign c1b    = instr_r[14:11];
  assign c2a    = instr_r[12:10];
  assign c2b    = instr_r[7:5];
  assign an     = instr_r[F_AN_HI:F_AN_LO];
  assign adrs   = instr_r[7:0];
  assign is_c1b = (instr_r[16:15] == CLS1B_CODE);
  assign is_c2a = (instr_r[16:13] == CLS2A_CODE);
  assign is_c2b = (instr_r[16:12] == CLS2B_CODE) && (instr_r[4:2] == CLS2B_TAIL);
  assign par_load = is_c1b && ((c1b == C1B_LMSH) || (c1b == C1B_LMAH));
  assign is_string = (is_c1b && instr_r[F_S] && !par_load && (c1b != C1B_RSV))
                   || (is_c2b && (instr_r[F_NEXTA_HI:F_NEXTA_LO] == NEXTA_STRING));
  assign last_cnt  = is_string ? str_len_r : 4'h0;
  assign fetch_c2b = (pmem[pc_r][16:12] == CLS2B_CODE) && (pmem[pc_r][4:2] == CLS2B_TAIL);

  // operand selection
  logic [2:0]        src_idx;
  logic [2:0]        dst_idx;
  logic [MEM_AW-1:0] dma;
  logic [7:0]        baddr;
  logic [15:0]       mem_word;
  logic [15:0]       mem_byte_word;
  logic [15:0]       long_const;
  logic [33:0]       prod34;
  logic [31:0]       shifted;

  always_comb begin
    src_idx = 3'(an) + 3'(cnt_r);
    dst_idx = src_idx;
    if (is_c2b) begin
      src_idx = {instr_r[F_SRCOFF], an} + 3'(cnt_r);
      dst_idx = {instr_r[F_DSTOFF], an} + 3'(cnt_r);
    end
  end

  assign dma           = adrs[MEM_AW-1:0] + MEM_AW'(cnt_r);
  assign baddr         = adrs + 8'(cnt_r);
  assign mem_word      = dmem[dma];
  assign mem_byte_word = dmem[baddr[MEM_AW:1]];
  assign long_const    = is_string ? pmem[second_r[MEM_AW-1:0] + MEM_AW'(cnt_r)][15:0]
                                   : second_r[15:0];
  assign prod34  = $signed({~um_r & mr_r[15], mr_r}) * $signed({~um_r & mem_word[15], mem_word});
  assign shifted = {(sign_extension_mode_r ? {16{mem_word[15]}} : 16'h0000), mem_word} << sv_r[3:0];

  // per-cycle operation
  logic [15:0] op_a;
  logic [15:0] op_b;
  alu_fn_t     fn;
  logic        wr_acc;
  logic        wr_dm;
  logic        wr_ph;
  logic        wr_mr;
  logic        um_clr;
  logic        upd_alu;
  logic        upd_xfer;
  logic [15:0] dm_wdata;
  logic [MEM_AW-1:0] dm_waddr;
  logic [15:0] ph_nxt;
  logic [15:0] mr_nxt;

  always_comb begin
    op_a     = acc_r[src_idx];
    op_b     = mem_word;
    fn       = FN_PASS;
    wr_acc   = 1'b0;
    wr_dm    = 1'b0;
    wr_ph    = 1'b0;
    wr_mr    = 1'b0;
    um_clr   = 1'b0;
    upd_alu  = 1'b0;
    upd_xfer = 1'b0;
    dm_wdata = 16'h0000;
    dm_waddr = dma;
    ph_nxt   = ph_r;
    mr_nxt   = mr_r;
    if (is_c1b) begin
      unique case (c1b)
        C1B_OR:  begin fn = FN_OR;  wr_acc = 1'b1; upd_alu = 1'b1; end
        C1B_AND: begin fn = FN_AND; wr_acc = 1'b1; upd_alu = 1'b1; end
        C1B_XOR: begin fn = FN_XOR; wr_acc = 1'b1; upd_alu = 1'b1; end
        C1B_LDB: begin
          op_b    = {8'h00, baddr[0] ? mem_byte_word[15:8] : mem_byte_word[7:0]};
          wr_acc  = 1'b1;
          upd_alu = 1'b1;
        end
        C1B_STB: begin
          op_b     = {8'h00, op_a[7:0]};
          dm_waddr = baddr[MEM_AW:1];
          dm_wdata = baddr[0] ? {op_a[7:0], mem_byte_word[7:0]}
                              : {mem_byte_word[15:8], op_a[7:0]};
          wr_dm    = 1'b1;
          upd_xfer = 1'b1;
        end
        C1B_CMP: begin fn = FN_SUB; upd_alu = 1'b1; end
        C1B_LUT: begin
          op_b     = pmem[op_a[MEM_AW-1:0]][15:0];
          dm_wdata = op_b;
          wr_dm    = 1'b1;
          upd_xfer = 1'b1;
        end
        C1B_MULT, C1B_MULA, C1B_MULS: begin
          op_b    = prod34[15:0];
          fn      = (c1b == C1B_MULA) ? FN_ADD : (c1b == C1B_MULS) ? FN_SUB : FN_PASS;
          ph_nxt  = prod34[31:16];
          wr_ph   = 1'b1;
          wr_acc  = 1'b1;
          upd_alu = 1'b1;
        end
        C1B_LMSH, C1B_LMAH: begin
          op_b    = ph_r;
          fn      = (c1b == C1B_LMAH) ? FN_ADD : FN_SUB;
          mr_nxt  = mem_word;
          wr_mr   = 1'b1;
          um_clr  = 1'b1;
          wr_acc  = 1'b1;
          upd_alu = 1'b1;
        end
        C1B_SHLT, C1B_SHLS, C1B_SHLA: begin
          op_b    = shifted[15:0];
          fn      = (c1b == C1B_SHLA) ? FN_ADD : (c1b == C1B_SHLS) ? FN_SUB : FN_PASS;
          ph_nxt  = shifted[31:16];
          wr_ph   = 1'b1;
          wr_acc  = 1'b1;
          upd_alu = 1'b1;
        end
        default: ;
      endcase
    end else if (is_c2a) begin
      op_b = {8'h00, adrs};
      unique case (c2a)
        C2A_ADD: begin fn = FN_ADD; wr_acc = 1'b1; upd_alu = 1'b1; end
        C2A_LD:  begin fn = FN_PASS; wr_acc = 1'b1; upd_alu = 1'b1; end
        C2A_SUB: begin fn = FN_SUB; wr_acc = 1'b1; upd_alu = 1'b1; end
        C2A_CMP: begin fn = FN_SUB; upd_alu = 1'b1; end
        C2A_OR:  begin fn = FN_OR;  wr_acc = 1'b1; upd_alu = 1'b1; end
        C2A_AND: begin fn = FN_AND; wr_acc = 1'b1; upd_alu = 1'b1; end
        C2A_XOR: begin fn = FN_XOR; wr_acc = 1'b1; upd_alu = 1'b1; end
        C2A_MR:  begin mr_nxt = {8'h00, adrs}; wr_mr = 1'b1; end
      endcase
    end else if (is_c2b) begin
      op_b = long_const;
      unique case (c2b)
        C2B_ADD: begin fn = FN_ADD; wr_acc = 1'b1; upd_alu = 1'b1; end
        C2B_LD:  begin fn = FN_PASS; wr_acc = 1'b1; upd_alu = 1'b1; end
        C2B_SUB: begin fn = FN_SUB; wr_acc = 1'b1; upd_alu = 1'b1; end
        C2B_CMP: begin fn = FN_SUB; upd_alu = 1'b1; end
        C2B_OR:  begin fn = FN_OR;  wr_acc = 1'b1; upd_alu = 1'b1; end
        C2B_AND: begin fn = FN_AND; wr_acc = 1'b1; upd_alu = 1'b1; end
        C2B_XOR: begin fn = FN_XOR; wr_acc = 1'b1; upd_alu = 1'b1; end
        C2B_MR:  begin mr_nxt = long_const; wr_mr = 1'b1; um_clr = 1'b1; end
      endcase
    end
  end

  // alu
  logic        chain;
  logic        arith_sub;
  logic [16:0] sum;
  logic [15:0] res;
  alu_status_t st_nxt;

  assign chain     = (cnt_r != 4'h0) || (par_load && instr_r[F_S]);
  assign arith_sub = (fn == FN_SUB);
  assign sum = {1'b0, op_a} + {1'b0, arith_sub ? ~op_b : op_b}
             + {16'h0000, chain ? st_r.carry : arith_sub};

  always_comb begin
    unique case (fn)
      FN_ADD, FN_SUB: res = sum[15:0];
      FN_OR:          res = op_a | op_b;
      FN_AND:         res = op_a & op_b;
      FN_XOR:         res = op_a ^ op_b;
      default:        res = op_b;
    endcase
    st_nxt.sign  = res[15];
    st_nxt.zero  = (res == 16'h0000) && (!chain || st_r.zero);
    st_nxt.carry = ((fn == FN_ADD) || (fn == FN_SUB)) ? sum[16] : st_r.carry;
  end

  logic exec_now;
  assign exec_now = (state_r == S_EXEC);

  // sequencer
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r  <= S_IDLE;
      pc_r     <= '0;
      cnt_r    <= 4'h0;
      busy_r   <= 1'b0;
      instr_r  <= '0;
      second_r <= '0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (sw_wr && (paddr == ADDR_CTRL) && pwdata[CTRL_GO]) begin
            pc_r    <= pwdata[CTRL_PC_LO +: MEM_AW];
            busy_r  <= 1'b1;
            state_r <= S_FETCH;
          end
        end
        S_FETCH: begin
          instr_r  <= pmem[pc_r];
          second_r <= pmem[pc_r + MEM_AW'(1)];
          cnt_r    <= 4'h0;
          state_r  <= fetch_c2b ? S_CONST : S_EXEC;
        end
        S_CONST: state_r <= S_EXEC;
        S_EXEC: begin
          if (cnt_r == last_cnt) begin
            busy_r  <= 1'b0;
            pc_r    <= pc_r + (is_c2b ? MEM_AW'(2) : MEM_AW'(1));
            state_r <= S_IDLE;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  // accumulators
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int i = 0; i < ACC_COUNT; i++) begin
        acc_r[i] <= 16'h0000;
      end
    end else if (exec_now && wr_acc) begin
      acc_r[dst_idx] <= res;
    end else if (sw_wr && is_acc_a) begin
      acc_r[paddr[4:2]] <= pwdata[15:0];
    end
  end

  // memories, not reset
  always_ff @(posedge core_clk) begin
    if (exec_now && wr_dm) begin
      dmem[dm_waddr] <= dm_wdata;
    end else if (sw_wr && is_dmem_a) begin
      dmem[paddr[7:2]] <= pwdata[15:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sw_wr && is_pmem_a) begin
      pmem[paddr[7:2]] <= pwdata[INSTR_W-1:0];
    end
  end

  // multiplier side registers and modes
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mr_r      <= 16'h0000;
      ph_r      <= 16'h0000;
      sv_r      <= 16'h0000;
      um_r      <= 1'b0;
      sign_extension_mode_r    <= 1'b0;
      str_len_r <= 4'h0;
    end else if (exec_now) begin
      if (wr_mr) mr_r <= mr_nxt;
      if (wr_ph) ph_r <= ph_nxt;
      if (um_clr) um_r <= 1'b0;
    end else if (sw_wr) begin
      if (paddr == ADDR_MR) mr_r <= pwdata[15:0];
      if (paddr == ADDR_PH) ph_r <= pwdata[15:0];
      if (paddr == ADDR_SV) sv_r <= pwdata[15:0];
      if (paddr == ADDR_STRLEN) str_len_r <= pwdata[3:0];
      if (paddr == ADDR_STATUS) begin
        um_r   <= pwdata[ST_UM];
        sign_extension_mode_r <= pwdata[ST_SIGN_EXTENSION_MODE];
      end
    end
  end

  // status flags
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= '0;
    end else if (exec_now && upd_alu) begin
      st_r <= st_nxt;
    end else if (exec_now && upd_xfer) begin
      st_r.sign <= st_nxt.sign;
      st_r.zero <= st_nxt.zero;
    end else if (sw_wr && (paddr == ADDR_STATUS)) begin
      st_r.carry <= pwdata[ST_CARRY];
      st_r.zero  <= pwdata[ST_ZERO];
      st_r.sign  <= pwdata[ST_SIGN];
    end
  end

  assign pready  = pready_r;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign busy    = busy_r;

endmodule : acc_mem_const_alu_ops

// File: hdl/acc_const_alu_pkg.sv
// shared constants and types for the accumulator, memory and constant datapath
package acc_const_alu_pkg;

  // register map, byte addresses on the register bus
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_STRLEN = 12'h008;
  localparam logic [11:0] ADDR_MR     = 12'h00C;
  localparam logic [11:0] ADDR_PH     = 12'h010;
  localparam logic [11:0] ADDR_SV     = 12'h014;
  localparam logic [6:0]  ACC_PAGE    = 7'h01;
  localparam logic [3:0]  DMEM_PAGE   = 4'h1;
  localparam logic [3:0]  PMEM_PAGE   = 4'h2;

  // control and status bit positions
  localparam int CTRL_GO    = 0;
  localparam int CTRL_BUSY  = 0;
  localparam int CTRL_PC_LO = 8;
  localparam int ST_CARRY   = 0;
  localparam int ST_ZERO    = 1;
  localparam int ST_SIGN    = 2;
  localparam int ST_UM      = 3;
  localparam int ST_SIGN_EXTENSION_MODE    = 4;

  // sizes
  localparam int MEM_AW    = 6;
  localparam int MEM_WORDS = 64;
  localparam int ACC_COUNT = 8;
  localparam int INSTR_W   = 17;

  // instruction fields
  localparam int F_AN_HI   = 9;
  localparam int F_AN_LO   = 8;
  localparam int F_S       = 10;
  localparam int F_NEXTA_HI = 11;
  localparam int F_NEXTA_LO = 10;
  localparam int F_SRCOFF  = 1;
  localparam int F_DSTOFF  = 0;

  localparam logic [1:0] CLS1B_CODE  = 2'b01;
  localparam logic [3:0] CLS2A_CODE  = 4'b1010;
  localparam logic [4:0] CLS2B_CODE  = 5'b11100;
  localparam logic [2:0] CLS2B_TAIL  = 3'b001;
  localparam logic [1:0] NEXTA_STRING = 2'b11;

  // memory-group codes
  localparam logic [3:0] C1B_OR   = 4'h0;
  localparam logic [3:0] C1B_AND  = 4'h1;
  localparam logic [3:0] C1B_XOR  = 4'h2;
  localparam logic [3:0] C1B_LDB  = 4'h3;
  localparam logic [3:0] C1B_STB  = 4'h4;
  localparam logic [3:0] C1B_RSV  = 4'h5;
  localparam logic [3:0] C1B_CMP  = 4'h6;
  localparam logic [3:0] C1B_LUT  = 4'h7;
  localparam logic [3:0] C1B_MULT = 4'h8;
  localparam logic [3:0] C1B_LMSH = 4'h9;
  localparam logic [3:0] C1B_LMAH = 4'hA;
  localparam logic [3:0] C1B_MULA = 4'hB;
  localparam logic [3:0] C1B_SHLT = 4'hC;
  localparam logic [3:0] C1B_SHLS = 4'hD;
  localparam logic [3:0] C1B_SHLA = 4'hE;
  localparam logic [3:0] C1B_MULS = 4'hF;

  // constant-group codes, shared by short and long forms
  localparam logic [2:0] C2A_ADD = 3'h0;
  localparam logic [2:0] C2A_LD  = 3'h1;
  localparam logic [2:0] C2A_SUB = 3'h2;
  localparam logic [2:0] C2A_CMP = 3'h3;
  localparam logic [2:0] C2A_OR  = 3'h4;
  localparam logic [2:0] C2A_AND = 3'h5;
  localparam logic [2:0] C2A_XOR = 3'h6;
  localparam logic [2:0] C2A_MR  = 3'h7;
  localparam logic [2:0] C2B_ADD = 3'h0;
  localparam logic [2:0] C2B_LD  = 3'h1;
  localparam logic [2:0] C2B_SUB = 3'h2;
  localparam logic [2:0] C2B_CMP = 3'h3;
  localparam logic [2:0] C2B_OR  = 3'h4;
  localparam logic [2:0] C2B_AND = 3'h5;
  localparam logic [2:0] C2B_XOR = 3'h6;
  localparam logic [2:0] C2B_MR  = 3'h7;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_FETCH = 2'b01,
    S_CONST = 2'b10,
    S_EXEC  = 2'b11
  } exec_state_t;

  typedef enum logic [2:0] {
    FN_PASS = 3'b000,
    FN_ADD  = 3'b001,
    FN_SUB  = 3'b010,
    FN_OR   = 3'b011,
    FN_AND  = 3'b100,
    FN_XOR  = 3'b101
  } alu_fn_t;

  typedef struct packed {
    logic sign;
    logic zero;
    logic carry;
  } alu_status_t;

endpackage : acc_const_alu_pkg

// File: test/acc_host_model.sv
// register-bus host model that loads memories and starts instructions
`timescale 1ns/100ps
module acc_host_model (
  input  wire logic        core_clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
  end
  // request held until pready sampled high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : acc_host_model

// File: test/acc_mem_const_alu_ops_assertions.sv
// port checker for the datapath block
`timescale 1ns/100ps
module acc_mem_const_alu_ops_chk
  import acc_const_alu_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence go_done;
    psel && penable && pready && pwrite && paddr == ADDR_CTRL && pwdata[0] && !busy;
  endsequence
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_ready_cause: assert property (pready |-> psel && penable) else $error("ready unasked");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_unmapped_err: assert property (pready && paddr == 12'h018
    |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped not refused");
  a_ctrl_ok: assert property (pready && paddr == ADDR_CTRL |-> !pslverr)
    else $error("control refused");
  a_go_busy: assert property (go_done |=> busy) else $error("go ignored");
  a_busy_min: assert property ($rose(busy) |=> busy) else $error("busy too short");
  a_busy_end: assert property ($rose(busy) |-> ##[1:20] !busy)
    else $error("busy too long");
endmodule : acc_mem_const_alu_ops_chk
bind acc_mem_const_alu_ops acc_mem_const_alu_ops_chk u_chk (.core_clk(core_clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .busy(busy));

// File: test/acc_mem_const_alu_ops_tb_top.sv
// self-checking bench for the datapath block
`timescale 1ns/100ps
module acc_mem_const_alu_ops_tb_top;
  import acc_const_alu_pkg::*;
  logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr, busy, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int          error_cnt, cmp_count;
  logic [3:0]  mc [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h5, 4'hB, 4'hF, 4'hC, 4'hE,
                           4'hD, 4'h8, 4'hA};
  logic [15:0] mv [13] = '{16'h0F0F, 16'h0F0F, 16'h0F0F, 16'hA50F, 16'h0F0F, 16'h0F0F,
                           16'h0010, 16'h0010, 16'h0123, 16'h0123, 16'h0123, 16'h8000,
                           16'h0007};
  logic [15:0] me [13] = '{16'h0FFF, 16'h000F, 16'h0FF0, 16'h00A5, 16'h00FF, 16'h00FF,
                           16'h011F, 16'h00DF, 16'h1230, 16'h132F, 16'hEECF, 16'h0000,
                           16'h00FE};
  logic [15:0] se [7] = '{16'h1243, 16'h000F, 16'h1225, 16'h1234, 16'h123F, 16'h0004,
                          16'h123B};
  acc_mem_const_alu_ops dut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .busy(busy));
  acc_host_model host (.core_clk(core_clk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask : wr
  task rc(input string n, input logic [11:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h00000000, q, e);
    chk(n, x, q);
  endtask : rc
  task run(input logic [16:0] ins);
    wr(12'h200, {15'h0000, ins});
    wr(ADDR_CTRL, 32'h00000001);
    do host.xfer(1'b0, ADDR_CTRL, 32'h00000000, q, e); while (q[0] !== 1'b0);
  endtask : run
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    test_done;
  end
  initial begin
    nrst = 1'b0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int k = 0; k < 7; k++) begin
      wr(12'h024, 32'h00001234);
      run({4'b1010, k[2:0], 2'd1, 8'h0F});
      rc("short acc", 12'h024, {16'h0000, se[k]});
      if (k == 3) rc("cmp status", ADDR_STATUS, 32'h00000001);
    end
    wr(ADDR_MR, 32'h0000FFFF);
    wr(ADDR_STATUS, 32'h00000008);
    run({4'b1010, 3'd7, 2'd0, 8'h0F});
    rc("short mr", ADDR_MR, 32'h0000000F);
    rc("mr status", ADDR_STATUS, 32'h00000008);
    wr(ADDR_STATUS, 32'h00000000);
    wr(ADDR_MR, 32'h00000002);
    wr(ADDR_SV, 32'h00000004);
    for (int k = 0; k < 13; k++) begin
      wr(12'h028, 32'h000000FF);
      wr(12'h114, {16'h0000, mv[k]});
      run({CLS1B_CODE, mc[k], 1'b0, 2'd2, (mc[k] == C1B_LDB) ? 8'h0B : 8'h05});
      rc("mem acc", 12'h028, {16'h0000, me[k]});
    end
    rc("ph", ADDR_PH, 32'h0000FFFF);
    rc("mr load", ADDR_MR, 32'h00000007);
    wr(12'h114, 32'h0000A50F);
    run({CLS1B_CODE, C1B_STB, 1'b0, 2'd2, 8'h0A});
    rc("byte store", 12'h114, 32'h0000A5FE);
    wr(12'h028, 32'h00000003);
    wr(12'h20C, 32'h00015A5A);
    run({CLS1B_CODE, C1B_LUT, 1'b0, 2'd2, 8'h06});
    rc("lookup", 12'h118, 32'h00005A5A);
    wr(ADDR_STRLEN, 32'h00000001);
    wr(12'h028, 32'h00000F00);
    wr(12'h02C, 32'h000000F0);
    wr(12'h114, 32'h0000000F);
    wr(12'h118, 32'h0000000F);
    run({CLS1B_CODE, C1B_OR, 1'b1, 2'd2, 8'h05});
    rc("string lo", 12'h028, 32'h00000F0F);
    rc("string hi", 12'h02C, 32'h000000FF);
    wr(12'h028, 32'h00000001);
    wr(12'h02C, 32'h00000005);
    wr(12'h114, 32'h00000000);
    wr(12'h118, 32'h00000005);
    run({CLS1B_CODE, C1B_CMP, 1'b1, 2'd2, 8'h05});
    rc("string cmp", ADDR_STATUS, 32'h00000001);
    wr(ADDR_PH, 32'h00000010);
    run({CLS1B_CODE, C1B_LMAH, 1'b1, 2'd2, 8'h05});
    rc("chain acc", 12'h028, 32'h00000012);
    rc("chain once", 12'h02C, 32'h00000005);
    wr(12'h020, 32'h00001000);
    wr(12'h030, 32'h00000200);
    wr(12'h204, 32'h00000034);
    run({CLS2B_CODE, 2'b00, 2'd0, C2B_ADD, CLS2B_TAIL, 1'b1, 1'b0});
    rc("long acc", 12'h020, 32'h00000234);
    rc("long offset", 12'h030, 32'h00000200);
    rc("long pc", ADDR_CTRL, 32'h00000200);
    run({CLS2B_CODE, 2'b00, 2'd0, C2B_CMP, CLS2B_TAIL, 2'b00});
    rc("long cmp", ADDR_STATUS, 32'h00000001);
    rc("cmp keeps", 12'h020, 32'h00000234);
    wr(ADDR_STATUS, 32'h00000008);
    run({CLS2B_CODE, 2'b00, 2'd0, C2B_MR, CLS2B_TAIL, 2'b00});
    rc("long mr", ADDR_MR, 32'h00000034);
    rc("mr signed", ADDR_STATUS, 32'h00000000);
    wr(ADDR_STATUS, 32'h00000010);
    wr(12'h114, 32'h00008001);
    run({CLS1B_CODE, C1B_SHLT, 1'b0, 2'd2, 8'h05});
    rc("sign fill", ADDR_PH, 32'h0000FFF8);
    rc("shift low", 12'h028, 32'h00000010);
    host.xfer(1'b0, 12'h018, 32'h00000000, q, e);
    chk("unmapped err", 32'h00000001, {31'h00000000, e});
    chk("unmapped data", 32'h00000000, q);
    test_done;
  end
endmodule : acc_mem_const_alu_ops_tb_top
